// *** verilog/sea_regs.svh ***
`ifndef SEA_REGS_SVH
`define SEA_REGS_SVH

// Task-file addresses on the link
`define SEA_TF_ERRFEAT   3'h1
`define SEA_TF_COUNT     3'h2
`define SEA_TF_SECNUM    3'h3
`define SEA_TF_SIGLO     3'h4
`define SEA_TF_SIGHI     3'h5
`define SEA_TF_DRVSEL    3'h6
`define SEA_TF_OPSTAT    3'h7

// Command and subcommand codes
`define SEA_OP_SMART     8'hB0
`define SEA_SUB_AUTOSAVE 8'hD2
`define SEA_SUB_ENABLE   8'hD8
`define SEA_SUB_DISABLE  8'hD9
`define SEA_SIG_LOW      8'h4F
`define SEA_SIG_HIGH     8'hC2
`define SEA_AS_OFF       8'h00
`define SEA_AS_ON        8'hF1

// Field positions
`define SEA_ST_BSY       7
`define SEA_ST_DRDY      6
`define SEA_ST_DF        5
`define SEA_ST_DRQ       3
`define SEA_ST_ERR       0
`define SEA_ERR_ABRT     2
`define SEA_DEV_BIT      4

// Reset values
`define SEA_STATUS_RST   8'h80
`define SEA_ERROR_RST    8'h00

// Timing
`define SEA_CLK_HZ        25000000
`define SEA_RESP_LIMIT_MS 2000

// Host controller registers (AHB-Lite byte offsets)
`define SEA_HR_CMD       32'h0000_0000
`define SEA_HR_STAT      32'h0000_0004
`define SEA_CMD_FEAT_LO  0
`define SEA_CMD_CNT_LO   8
`define SEA_CMD_DEV      16
`define SEA_STAT_BUSY    0
`define SEA_STAT_DONE    1
`define SEA_STAT_REFUSED 2
`define SEA_STAT_SMART   3
`define SEA_STAT_ST_LO   8
`define SEA_STAT_ER_LO   16

`endif

// *** verilog/sea_pkg.sv ***
package sea_pkg;

    typedef enum logic [1:0] {
        DV_LOAD,
        DV_IDLE,
        DV_EXEC
    } sea_dev_state_t;

    typedef struct packed {
        sea_dev_state_t st;
        logic [7:0]     feat;
        logic [7:0]     count;
        logic [7:0]     secnum;
        logic [7:0]     siglo;
        logic [7:0]     sighi;
        logic [7:0]     drvsel;
        logic [7:0]     opcode;
        logic [7:0]     status;
        logic [7:0]     error;
        logic [7:0]     rdata;
        logic           smart_on;
        logic [7:0]     autosave;
        logic           nv_wr;
        logic [25:0]    wait_cnt;
    } sea_dev_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_RD,
        H_RD_W,
        H_RD_C,
        H_WR
    } sea_host_state_t;

    typedef enum logic [1:0] {
        PH_PRE,
        PH_POLL,
        PH_ERR
    } sea_phase_t;

    typedef struct packed {
        sea_host_state_t st;
        sea_phase_t      ph;
        logic [2:0]      idx;
        logic [7:0]      feat;
        logic [7:0]      count;
        logic            dev;
        logic            busy;
        logic            done;
        logic            refused;
        logic            smart_known;
        logic [7:0]      dstat;
        logic [7:0]      derr;
        logic            l_wr;
        logic            l_rd;
        logic [2:0]      l_addr;
        logic [7:0]      l_wdata;
        logic            ap_wr;
        logic            ap_rd;
        logic [31:0]     ap_addr;
        logic [31:0]     hrdata;
    } sea_host_t;

endpackage

// *** verilog/sea_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface sea_link_if;
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport dev (
        input  wr,
        input  rd,
        input  addr,
        input  wdata,
        output rdata
    );

    modport host (
        output wr,
        output rd,
        output addr,
        output wdata,
        input  rdata
    );
endinterface

`default_nettype wire

// *** verilog/sea_device.sv ***
// Functional notes
// - Normal completion: BSY,DF,DRQ,ERR clear, DRDY set
// - Abort: ABRT, ERR set; DF on fault
// - Abort allowed when action cannot complete
// - Disable aborts: unsupported, SMART off, bad inputs
// - Disable stops all SMART monitoring and saving
// - SMART on/off state kept nonvolatile
// - SMART off aborts all but enable
// - Autosave is B0h with subcommand D2h
// - Count 00h disables, F1h enables autosave
// - Other nonzero counts retained across power cycles
// - Autosave state kept nonvolatile
// - Autosave aborts: unsupported, SMART off, bad inputs
// - Background autosave never sets BSY, clears DRDY
// - Answer within two seconds during autosave
// - Saving at power or recovery still allowed
// - Enable is B0h with subcommand D8h
// - Host loads signature 4Fh and C2h first
// - Enable aborts only on bad inputs; code also aborts it on dev_fault, cannot_complete or autosave timeout
// - Host issues only with DRDY, SMART rules
// - Device-select bit picks executing device
// - Non-data protocol, DRQ never set
// - Disable is B0h with subcommand D9h
// - Repeated enable leaves SMART state untouched
`timescale 1ns/100ps
`default_nettype none
`include "sea_regs.svh"

module sea_device #(
    parameter int unsigned RESP_CYCLES =
        `SEA_RESP_LIMIT_MS * (`SEA_CLK_HZ / 1000)
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    sea_link_if.dev         link,
    input  wire logic       dev_id,
    input  wire logic       nv_smart_in,
    input  wire logic [7:0] nv_autosave_in,
    input  wire logic       dev_fault,
    input  wire logic       cannot_complete,
    input  wire logic       autosave_active,
    output logic            nv_wr,
    output logic            nv_smart_out,
    output logic [7:0]      nv_autosave_out,
    output logic            smart_monitor_en,
    output logic            autosave_en,
    output logic            autosave_yield
);

    localparam sea_pkg::sea_dev_t RST_VAL = '{
        st:     sea_pkg::DV_LOAD,
        status: `SEA_STATUS_RST,
        error:  `SEA_ERROR_RST,
        default: '0
    };
    localparam logic [25:0] WAIT_LAST = 26'(RESP_CYCLES - 1);

    sea_pkg::sea_dev_t r_reg;
    sea_pkg::sea_dev_t r_next;

    logic sig_ok;
    logic sub_ok;
    logic abort;
    logic selected;

    // Signature must match in every bit
    assign sig_ok = (r_reg.siglo == `SEA_SIG_LOW) &&
                    (r_reg.sighi == `SEA_SIG_HIGH);

    assign selected = (r_reg.drvsel[`SEA_DEV_BIT] == dev_id);

    always_comb begin
        case (r_reg.feat)
            `SEA_SUB_ENABLE: begin
                sub_ok = 1'b1;
            end
            `SEA_SUB_DISABLE: begin
                sub_ok = r_reg.smart_on;
            end
            `SEA_SUB_AUTOSAVE: begin
                sub_ok = r_reg.smart_on;
            end
            default: begin
                sub_ok = 1'b0;
            end
        endcase
    end

    // Timeout on a stuck autosave is treated as unable to complete
    assign abort = (r_reg.opcode != `SEA_OP_SMART) || !sig_ok || !sub_ok
                   || cannot_complete || dev_fault
                   || autosave_active;

    always_comb begin
        r_next       = r_reg;
        r_next.nv_wr = 1'b0;

        case (link.addr)
            `SEA_TF_ERRFEAT: begin
                r_next.rdata = r_reg.error;
            end
            `SEA_TF_COUNT: begin
                r_next.rdata = r_reg.count;
            end
            `SEA_TF_SECNUM: begin
                r_next.rdata = r_reg.secnum;
            end
            `SEA_TF_SIGLO: begin
                r_next.rdata = r_reg.siglo;
            end
            `SEA_TF_SIGHI: begin
                r_next.rdata = r_reg.sighi;
            end
            `SEA_TF_DRVSEL: begin
                r_next.rdata = r_reg.drvsel;
            end
            `SEA_TF_OPSTAT: begin
                r_next.rdata = r_reg.status;
            end
            default: begin
                r_next.rdata = 8'h00;
            end
        endcase

        // Parameter writes while busy are dropped to keep the decode stable
        if (link.wr && r_reg.st == sea_pkg::DV_IDLE) begin
            case (link.addr)
                `SEA_TF_ERRFEAT: begin
                    r_next.feat = link.wdata;
                end
                `SEA_TF_COUNT: begin
                    r_next.count = link.wdata;
                end
                `SEA_TF_SECNUM: begin
                    r_next.secnum = link.wdata;
                end
                `SEA_TF_SIGLO: begin
                    r_next.siglo = link.wdata;
                end
                `SEA_TF_SIGHI: begin
                    r_next.sighi = link.wdata;
                end
                `SEA_TF_DRVSEL: begin
                    r_next.drvsel = link.wdata;
                end
                `SEA_TF_OPSTAT: begin
                    if (selected) begin
                        r_next.opcode              = link.wdata;
                        r_next.status[`SEA_ST_BSY] = 1'b1;
                        r_next.status[`SEA_ST_DRQ] = 1'b0;
                        r_next.wait_cnt            = '0;
                        r_next.st                  = sea_pkg::DV_EXEC;
                    end
                end
                default: begin
                end
            endcase
        end

        case (r_reg.st)
            sea_pkg::DV_LOAD: begin
                // Persistent state captured after reset release
                r_next.smart_on = nv_smart_in;
                r_next.autosave = nv_autosave_in;
                r_next.status   = 8'h00;
                r_next.status[`SEA_ST_DRDY] = 1'b1;
                r_next.st       = sea_pkg::DV_IDLE;
            end
            sea_pkg::DV_IDLE: begin
            end
            sea_pkg::DV_EXEC: begin
                if (autosave_active && r_reg.wait_cnt != WAIT_LAST) begin
                    r_next.wait_cnt = r_reg.wait_cnt + 26'h0000001;
                end else begin
                    r_next.status = 8'h00;
                    r_next.status[`SEA_ST_DRDY] = 1'b1;
                    r_next.status[`SEA_ST_DF]   = dev_fault;
                    r_next.status[`SEA_ST_ERR]  = abort;
                    r_next.error = 8'h00;
                    r_next.error[`SEA_ERR_ABRT] = abort;
                    r_next.st = sea_pkg::DV_IDLE;
                    if (!abort) begin
                        case (r_reg.feat)
                            `SEA_SUB_ENABLE: begin
                                // Already on: nothing is touched
                                r_next.smart_on = 1'b1;
                                r_next.nv_wr    = !r_reg.smart_on;
                            end
                            `SEA_SUB_DISABLE: begin
                                r_next.smart_on = 1'b0;
                                r_next.nv_wr    = 1'b1;
                            end
                            `SEA_SUB_AUTOSAVE: begin
                                // Any nonzero value is kept as given
                                r_next.autosave = r_reg.count;
                                r_next.nv_wr    = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: begin
                r_next.st = sea_pkg::DV_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= RST_VAL;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.rdata       = r_reg.rdata;
    assign nv_wr            = r_reg.nv_wr;
    assign nv_smart_out     = r_reg.smart_on;
    assign nv_autosave_out  = r_reg.autosave;
    assign smart_monitor_en = r_reg.smart_on;
    // Power and recovery saves stay with the drive firmware
    assign autosave_en      = r_reg.smart_on &&
                              (r_reg.autosave != `SEA_AS_OFF);
    // Autosave is asked to yield; still active at the limit, it makes the command end aborted
    assign autosave_yield   = (r_reg.st == sea_pkg::DV_EXEC);

endmodule

`default_nettype wire

// *** verilog/sea_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sea_regs.svh"

module sea_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    sea_link_if.host         link
);

    sea_pkg::sea_host_t r_reg;
    sea_pkg::sea_host_t r_next;

    logic       ap_take;
    logic       start;
    logic [7:0] st_in;

    assign ap_take = hsel && hready && htrans[1] && (hsize == 3'h2);
    assign start   = r_reg.ap_wr && !r_reg.busy &&
                     (r_reg.ap_addr == `SEA_HR_CMD);
    assign st_in   = link.rdata;

    always_comb begin
        r_next      = r_reg;
        r_next.l_wr = 1'b0;
        r_next.l_rd = 1'b0;

        r_next.ap_wr   = ap_take && hwrite;
        r_next.ap_rd   = ap_take && !hwrite;
        r_next.ap_addr = haddr;
        if (ap_take && !hwrite) begin
            r_next.hrdata = 32'h0000_0000;
            if (haddr == `SEA_HR_STAT) begin
                r_next.hrdata[`SEA_STAT_BUSY]    = r_reg.busy;
                r_next.hrdata[`SEA_STAT_DONE]    = r_reg.done;
                r_next.hrdata[`SEA_STAT_REFUSED] = r_reg.refused;
                r_next.hrdata[`SEA_STAT_SMART]   = r_reg.smart_known;
                r_next.hrdata[`SEA_STAT_ST_LO+:8] = r_reg.dstat;
                r_next.hrdata[`SEA_STAT_ER_LO+:8] = r_reg.derr;
            end
        end

        case (r_reg.st)
            sea_pkg::H_IDLE: begin
                if (start) begin
                    r_next.feat    = hwdata[`SEA_CMD_FEAT_LO+:8];
                    r_next.count   = hwdata[`SEA_CMD_CNT_LO+:8];
                    r_next.dev     = hwdata[`SEA_CMD_DEV];
                    r_next.busy    = 1'b1;
                    r_next.done    = 1'b0;
                    r_next.refused = 1'b0;
                    r_next.ph      = sea_pkg::PH_PRE;
                    r_next.st      = sea_pkg::H_RD;
                end
            end
            sea_pkg::H_RD: begin
                r_next.l_rd   = 1'b1;
                r_next.l_addr = (r_reg.ph == sea_pkg::PH_ERR) ?
                                `SEA_TF_ERRFEAT : `SEA_TF_OPSTAT;
                r_next.st     = sea_pkg::H_RD_W;
            end
            sea_pkg::H_RD_W: begin
                r_next.st = sea_pkg::H_RD_C;
            end
            sea_pkg::H_RD_C: begin
                r_next.st = sea_pkg::H_RD;
                case (r_reg.ph)
                    sea_pkg::PH_PRE: begin
                        // Wait for a ready, idle device
                        if (!st_in[`SEA_ST_BSY] && st_in[`SEA_ST_DRDY]) begin
                            if (r_reg.feat != `SEA_SUB_ENABLE &&
                                !r_reg.smart_known) begin
                                r_next.refused = 1'b1;
                                r_next.done    = 1'b1;
                                r_next.busy    = 1'b0;
                                r_next.st      = sea_pkg::H_IDLE;
                            end else begin
                                r_next.idx = 3'h0;
                                r_next.st  = sea_pkg::H_WR;
                            end
                        end
                    end
                    sea_pkg::PH_POLL: begin
                        if (!st_in[`SEA_ST_BSY]) begin
                            r_next.dstat = st_in;
                            r_next.derr  = 8'h00;
                            if (st_in[`SEA_ST_ERR]) begin
                                r_next.ph = sea_pkg::PH_ERR;
                            end else begin
                                if (r_reg.feat == `SEA_SUB_ENABLE) begin
                                    r_next.smart_known = 1'b1;
                                end
                                if (r_reg.feat == `SEA_SUB_DISABLE) begin
                                    r_next.smart_known = 1'b0;
                                end
                                r_next.done = 1'b1;
                                r_next.busy = 1'b0;
                                r_next.st   = sea_pkg::H_IDLE;
                            end
                        end
                    end
                    default: begin
                        r_next.derr = st_in;
                        r_next.done = 1'b1;
                        r_next.busy = 1'b0;
                        r_next.st   = sea_pkg::H_IDLE;
                    end
                endcase
            end
            sea_pkg::H_WR: begin
                r_next.l_wr = 1'b1;
                r_next.idx  = r_reg.idx + 3'h1;
                case (r_reg.idx)
                    3'h0: begin
                        r_next.l_addr  = `SEA_TF_ERRFEAT;
                        r_next.l_wdata = r_reg.feat;
                    end
                    3'h1: begin
                        r_next.l_addr  = `SEA_TF_COUNT;
                        r_next.l_wdata = r_reg.count;
                    end
                    3'h2: begin
                        r_next.l_addr  = `SEA_TF_SIGLO;
                        r_next.l_wdata = `SEA_SIG_LOW;
                    end
                    3'h3: begin
                        r_next.l_addr  = `SEA_TF_SIGHI;
                        r_next.l_wdata = `SEA_SIG_HIGH;
                    end
                    3'h4: begin
                        r_next.l_addr  = `SEA_TF_DRVSEL;
                        r_next.l_wdata = 8'h00;
                        r_next.l_wdata[`SEA_DEV_BIT] = r_reg.dev;
                    end
                    default: begin
                        // Command goes last, after every parameter
                        r_next.l_addr  = `SEA_TF_OPSTAT;
                        r_next.l_wdata = `SEA_OP_SMART;
                        r_next.ph      = sea_pkg::PH_POLL;
                        r_next.st      = sea_pkg::H_RD;
                    end
                endcase
            end
            default: begin
                r_next.st = sea_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hrdata     = r_reg.hrdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign link.wr    = r_reg.l_wr;
    assign link.rd    = r_reg.l_rd;
    assign link.addr  = r_reg.l_addr;
    assign link.wdata = r_reg.l_wdata;

endmodule

`default_nettype wire

// *** bench/sea_link_sva.sv ***
`timescale 1ns/100ps
`default_nettype none

module sea_link_sva (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       wr,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       dev_id
);
    logic [2:0] addr_q;
    logic       wr_q;
    logic       pend;
    logic       pend_bad;
    logic [7:0] feat_r;
    logic [7:0] lo_r;
    logic [7:0] hi_r;
    logic [7:0] sel_r;
    // Read data lags the address by one cycle
    wire logic  st_rd = addr_q == 3'h7 && !wr_q;
    wire logic  er_rd = addr_q == 3'h1 && !wr_q;
    wire logic  go    = wr && addr == 3'h7 && sel_r[4] == dev_id;
    wire logic  other = wr && addr == 3'h7 && sel_r[4] != dev_id;
    wire logic  bad   = wdata != 8'hB0 || lo_r != 8'h4F || hi_r != 8'hC2
                        || !(feat_r inside {8'hD2, 8'hD8, 8'hD9});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q   <= 3'h0;
            wr_q     <= 1'b0;
            pend     <= 1'b0;
            pend_bad <= 1'b0;
            feat_r   <= 8'h00;
            lo_r     <= 8'h00;
            hi_r     <= 8'h00;
            sel_r    <= 8'h00;
        end else begin
            addr_q <= addr;
            wr_q   <= wr;
            if (wr && addr == 3'h1) feat_r <= wdata;
            if (wr && addr == 3'h4) lo_r <= wdata;
            if (wr && addr == 3'h5) hi_r <= wdata;
            if (wr && addr == 3'h6) sel_r <= wdata;
            if (go) begin
                pend     <= 1'b1;
                pend_bad <= bad;
            end else if (st_rd && !rdata[7]) begin
                pend <= 1'b0;
            end
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_done;
        st_rd && !rdata[7];
    endsequence

    AST_NO_DRQ: assert property (st_rd |-> !rdata[3])
        else $error("status shows data request");
    AST_DONE_OK: assert property (st_rd && !rdata[7] && !rdata[0]
        |-> rdata == 8'h40)
        else $error("normal completion status wrong");
    AST_DF_ERR: assert property (st_rd && rdata[5] |-> rdata[0] && rdata[6])
        else $error("fault without error and ready");
    AST_ERR_BITS: assert property (er_rd |-> (rdata & 8'hFB) == 8'h00)
        else $error("error bit other than abort");
    AST_RESP_BOUND: assert property (go |-> ##[2:60] s_done)
        else $error("no completion in time");
    AST_BAD_ABORT: assert property (pend && pend_bad && st_rd && !rdata[7]
        |-> rdata[0])
        else $error("invalid inputs not aborted");
    AST_ABRT_READ: assert property (pend && st_rd && !rdata[7] && rdata[0]
        |-> ##[1:12] (er_rd && rdata == 8'h04))
        else $error("abort without abort bit");
    AST_OTHER_DEV: assert property (other |-> ##1 (!(st_rd && rdata[7]))[*8])
        else $error("command for other device executed");
endmodule

`default_nettype wire

// *** bench/smart_enable_autosave_cmd_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sea_regs.svh"

module smart_enable_autosave_cmd_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    wire logic   hready = hreadyout;
    logic        nv_smart_in = 1'b0;
    logic [7:0]  nv_autosave_in = 8'h00;
    logic        dev_fault = 1'b0;
    logic        cannot_complete = 1'b0;
    logic        autosave_active = 1'b0;
    logic        nv_wr;
    logic        nv_smart_out;
    logic [7:0]  nv_autosave_out;
    logic        smart_monitor_en;
    logic        autosave_en;
    logic        autosave_yield;
    int          err_total = 0;
    int          check_count = 0;
    integer      seed = 32'h1da2c047;
    logic        smart = 1'b0;
    logic        known = 1'b0;
    logic [7:0]  as_val = 8'h00;
    logic [7:0]  lst = 8'h40;
    logic [31:0] rv;
    logic [7:0]  fs [4] = '{8'hD2, 8'hD8, 8'hD9, 8'hD5};
    logic [23:0] tbl [16] = '{
        24'h00D900, 24'h00D800, 24'h00D800, 24'h00D2F1,
        24'h00D25A, 24'h80D800, 24'h00D200, 24'h00D400,
        24'h01D900, 24'h10D800, 24'h20D2F1, 24'h40D800,
        24'h00D900, 24'h00D900, 24'h00D2F1, 24'h80D800};

    sea_link_if sea_link_if_i ();

    sea_host sea_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(sea_link_if_i));

    sea_device #(.RESP_CYCLES(20)) sea_device_i (.hclk(hclk),
        .hresetn(hresetn), .link(sea_link_if_i), .dev_id(1'b0),
        .nv_smart_in(nv_smart_in), .nv_autosave_in(nv_autosave_in),
        .dev_fault(dev_fault), .cannot_complete(cannot_complete),
        .autosave_active(autosave_active), .nv_wr(nv_wr),
        .nv_smart_out(nv_smart_out), .nv_autosave_out(nv_autosave_out),
        .smart_monitor_en(smart_monitor_en), .autosave_en(autosave_en),
        .autosave_yield(autosave_yield));

    sea_link_sva sea_link_sva_i (.hclk(hclk), .hresetn(hresetn),
        .wr(sea_link_if_i.wr), .addr(sea_link_if_i.addr),
        .wdata(sea_link_if_i.wdata), .rdata(sea_link_if_i.rdata),
        .dev_id(1'b0));

    always #20 hclk = ~hclk;

    // Persistent store only takes what the device asks to keep
    always @(posedge hclk) begin
        if (nv_wr === 1'b1) begin
            nv_smart_in    <= nv_smart_out;
            nv_autosave_in <= nv_autosave_out;
        end
    end

    task automatic chk8(input logic [7:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic chk1(input logic g, e, input string m);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic cmd(input logic [7:0] f, c, input logic d);
        logic [31:0] r;
        logic        rf;
        logic        ok;
        int          n;
        ahb(1'b1, `SEA_HR_CMD, {15'h0, d, c, f}, r);
        n = 0;
        do begin
            ahb(1'b0, `SEA_HR_STAT, 32'h0, r);
            n++;
        end while ((r[0] !== 1'b0 || r[1] !== 1'b1) && n < 200);
        // Host only lets enable through until it has seen SMART on
        rf = f != 8'hD8 && !known;
        ok = (f == 8'hD8 || f inside {8'hD2, 8'hD9} && smart)
             && !dev_fault && !cannot_complete && !autosave_active;
        chk1(r[2], rf, "refused");
        chk1(r[1] & ~r[0], 1'b1, "finished");
        if (!rf && !d) begin
            chk8(r[15:8], ok ? 8'h40 : dev_fault ? 8'h61 : 8'h41, "status");
            chk8(r[23:16], ok ? 8'h00 : 8'h04, "error");
            if (ok && f == 8'hD8) {smart, known} = 2'b11;
            if (ok && f == 8'hD9) {smart, known} = 2'b00;
            if (ok && f == 8'hD2) as_val = c;
            lst = ok ? 8'h40 : dev_fault ? 8'h61 : 8'h41;
        end
        // Other device stays silent: host sees the last status again
        if (!rf && d) begin
            chk8(r[15:8], lst, "ignored status");
            chk8(r[23:16], lst[0] ? 8'h04 : 8'h00, "ignored error");
            if (!lst[0] && f == 8'hD9) known = 1'b0;
        end
        @(posedge hclk);
        chk1(autosave_yield, 1'b0, "yield");
        chk1(smart_monitor_en, smart, "monitor");
        chk1(autosave_en, smart && as_val != 8'h00, "autosave");
    endtask

    task automatic pcycle;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        known = 1'b0;
        lst = 8'h40;
        repeat (3) @(posedge hclk);
        chk1(smart_monitor_en, smart, "kept monitor");
        chk1(autosave_en, smart && as_val != 8'h00, "kept autosave");
    endtask

    task automatic step(input logic [23:0] e);
        if (e[23]) pcycle;
        {autosave_active, cannot_complete, dev_fault} <= e[22:20];
        cmd(e[15:8], e[7:0], e[16]);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        // Fixed corners: refusal, repeats, faults, autosave stall, disable
        for (int i = 0; i < 16; i++) step(tbl[i]);
        for (int i = 0; i < 40; i++) begin
            rv = $random(seed);
            // Random subcommands, counts, faults; other device never D8
            rv[15:8] = rv[3] ? fs[rv[1:0]] : rv[15:8];
            rv[7:0] = rv[6] ? rv[31:24] : (rv[5] ? 8'hF1 : 8'h00);
            rv[16] = rv[19:17] == 3'h0 && rv[15:8] != 8'hD8;
            rv[23:20] = {3'h0, rv[22:20] == 3'h0};
            step(rv[23:0]);
        end
        report_and_stop;
    end

    // Whole run is around a thousand cycles
    initial begin
        #(40 * 40000);
        err_total++;
        report_and_stop;
    end
endmodule

`default_nettype wire
